// >>> src/frdc_dummy_select.sv
`timescale 1ns/100ps
`include "frdc_params.svh"
// Functional notes
// RULE1: nonzero four-bit latency N gives exactly N dummy cycles on fast reads.
// RULE2: latency zero: single fast read 0Bh/0Dh uses 8 four-wire, 6 quad mode.
// RULE3: latency zero: dual-output read 3Bh uses 8; it has no double-rate form.
// RULE4: latency zero: dual input/output read BBh and BDh use 4.
// RULE5: latency zero: quad-output read 6Bh uses 8; it has no double-rate form.
// RULE6: latency zero: quad input/output read EBh and EDh use 6 in both modes.
// RULE7: host keeps its serial clock within the limit for the chosen latency.
// RULE8: host floats trailing mode bits when dummy count equals mode phase length.
// RULE9: double-rate dual input/output read BDh is refused in quad command mode.
// RULE10: four-wire mode: ID, parameter and info-row reads follow the 0Bh count.
// RULE11: quad mode: ID and info-row reads follow the 0Bh count.
// RULE12: dummies count serial clocks after the last address/mode cycle, then data.
module frdc_dummy_select
  import frdc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] cfg_latency,
  input wire logic cfg_quad_command_mode,
  input wire logic sck,
  input wire logic lk_cs_n,
  input wire logic [7:0] lk_cmd,
  input wire logic lk_phase_end,
  output logic lk_data_drive,
  output logic lk_cmd_reject,
  output logic [3:0] lk_dummy_count,
  output logic read_start,
  output logic read_refused
);

  ////////////////////////////////////////////////////////////////////////
  // system side: hold the configuration in flops before it leaves

  logic [3:0] latency;
  logic quad_mode;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latency <= `FRDC_LAT_RESET;
      quad_mode <= 1'b0;
    end else begin
      latency <= cfg_latency;
      quad_mode <= cfg_quad_command_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link side: config crosses as levels; it is quasi-static, so a change
  // only lands on the serial clocks of a later frame

  logic lk_rst_n;
  logic [4:0] lk_cfg_meta;
  logic [4:0] lk_cfg;

  // frame end clears the link config sync, state and flags (not the count or toggles), since the serial clock stops with it
  assign lk_rst_n = arst_n & ~lk_cs_n;

  always_ff @(posedge sck or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_cfg_meta <= 5'h00;
      lk_cfg <= 5'h00;
    end else begin
      lk_cfg_meta <= {quad_mode, latency};
      lk_cfg <= lk_cfg_meta;
    end
  end

  // dummy count for a command; zero marks a command that is refused
  function automatic logic [3:0] frdc_select(input logic [7:0] cmd,
                                             input logic [3:0] lat,
                                             input logic quad);
    logic [3:0] def;
    logic ok;
    def = 4'h0;
    ok = 1'b1;
    if (cmd == `FRDC_CMD_FAST_READ || cmd == `FRDC_CMD_SINGLE_DTR) begin
      def = quad ? `FRDC_DEF_SINGLE_QUAD : `FRDC_DEF_SINGLE_4W; // RULE2
    end else if (cmd == `FRDC_CMD_UID_READ || cmd == `FRDC_CMD_INFO_READ) begin
      def = quad ? `FRDC_DEF_SINGLE_QUAD : `FRDC_DEF_SINGLE_4W; // RULE10 RULE11
    end else if (cmd == `FRDC_CMD_PARAM_READ) begin
      def = quad ? `FRDC_DEF_PARAM_QUAD : `FRDC_DEF_SINGLE_4W; // RULE10
    end else if (cmd == `FRDC_CMD_DUAL_OUT) begin
      def = `FRDC_DEF_DUAL_OUT; // RULE3
    end else if (cmd == `FRDC_CMD_DUAL_IO) begin
      def = `FRDC_DEF_DUAL_IO; // RULE4
    end else if (cmd == `FRDC_CMD_DUAL_IO_DTR) begin
      def = `FRDC_DEF_DUAL_IO; // RULE4
      ok = ~quad; // RULE9
    end else if (cmd == `FRDC_CMD_QUAD_OUT) begin
      def = `FRDC_DEF_QUAD_OUT; // RULE5
    end else if (cmd == `FRDC_CMD_QUAD_IO || cmd == `FRDC_CMD_QUAD_IO_DTR) begin
      def = `FRDC_DEF_QUAD_IO; // RULE6
    end else begin
      ok = 1'b0;
    end
    if (!ok) begin
      frdc_select = 4'h0;
    end else if (lat != 4'h0) begin
      frdc_select = lat; // RULE1
    end else begin
      frdc_select = def;
    end
  endfunction

  frdc_state_t state;
  frdc_state_t next_state;
  logic [3:0] remain;
  logic [3:0] next_remain;
  logic [3:0] sel;

  assign sel = frdc_select(lk_cmd, lk_cfg[3:0], lk_cfg[4]);

  always_comb begin
    next_state = state;
    next_remain = remain;
    case (state)
      FRDC_IDLE: begin
        if (lk_phase_end) begin
          if (sel == 4'h0) begin
            next_state = FRDC_REJECT; // RULE9
          end else begin
            next_state = FRDC_DUMMY;
            next_remain = sel;
          end
        end
      end
      FRDC_DUMMY: begin
        next_remain = remain - 4'h1;
        if (remain == 4'h1) begin
          next_state = FRDC_DATA; // RULE12
        end
      end
      FRDC_DATA: begin
        next_state = FRDC_DATA;
      end
      default: begin
        next_state = FRDC_REJECT;
      end
    endcase
  end

  always_ff @(posedge sck or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      state <= FRDC_IDLE;
      remain <= 4'h0;
    end else begin
      state <= next_state;
      remain <= next_remain;
    end
  end

  always_ff @(posedge sck or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_data_drive <= 1'b0;
      lk_cmd_reject <= 1'b0;
    end else begin
      lk_data_drive <= (next_state == FRDC_DATA); // RULE12
      lk_cmd_reject <= (next_state == FRDC_REJECT);
    end
  end

  // count stays visible after the frame for the host's diagnostics
  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      lk_dummy_count <= 4'h0;
    end else if (state == FRDC_IDLE && lk_phase_end) begin
      lk_dummy_count <= sel;
    end
  end

  // events toward the system clock as toggles; these survive cs_n
  logic lk_start_tgl;
  logic lk_refuse_tgl;

  always_ff @(posedge sck or negedge arst_n) begin
    if (!arst_n) begin
      lk_start_tgl <= 1'b0;
      lk_refuse_tgl <= 1'b0;
    end else if (lk_cs_n) begin
      lk_start_tgl <= lk_start_tgl;
      lk_refuse_tgl <= lk_refuse_tgl;
    end else begin
      if (state == FRDC_DUMMY && remain == 4'h1) begin
        lk_start_tgl <= ~lk_start_tgl;
      end
      if (state == FRDC_IDLE && lk_phase_end && sel == 4'h0) begin
        lk_refuse_tgl <= ~lk_refuse_tgl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system side: synchronise toggles, turn edges into one-cycle pulses

  logic [1:0] start_meta;
  logic [1:0] start_sync;
  logic [1:0] start_prev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_meta <= 2'b00;
      start_sync <= 2'b00;
      start_prev <= 2'b00;
      read_start <= 1'b0;
      read_refused <= 1'b0;
    end else begin
      start_meta <= {lk_refuse_tgl, lk_start_tgl};
      start_sync <= start_meta;
      start_prev <= start_sync;
      read_start <= start_sync[0] ^ start_prev[0];
      read_refused <= start_sync[1] ^ start_prev[1];
    end
  end

endmodule

// >>> src/frdc_params.svh
`ifndef FRDC_PARAMS_SVH
`define FRDC_PARAMS_SVH

// read command codes
`define FRDC_CMD_FAST_READ 8'h0b
`define FRDC_CMD_SINGLE_DTR 8'h0d
`define FRDC_CMD_DUAL_OUT 8'h3b
`define FRDC_CMD_DUAL_IO 8'hbb
`define FRDC_CMD_DUAL_IO_DTR 8'hbd
`define FRDC_CMD_QUAD_OUT 8'h6b
`define FRDC_CMD_QUAD_IO 8'heb
`define FRDC_CMD_QUAD_IO_DTR 8'hed

// command codes whose values are open here; defaults are plain choices
`define FRDC_CMD_UID_READ 8'h4b
`define FRDC_CMD_PARAM_READ 8'h5a
`define FRDC_CMD_INFO_READ 8'h68

// dummy counts used when the latency field is zero
`define FRDC_DEF_SINGLE_4W 4'h8
`define FRDC_DEF_SINGLE_QUAD 4'h6
`define FRDC_DEF_DUAL_OUT 4'h8
`define FRDC_DEF_DUAL_IO 4'h4
`define FRDC_DEF_QUAD_OUT 4'h8
`define FRDC_DEF_QUAD_IO 4'h6
`define FRDC_DEF_PARAM_QUAD 4'h8

// latency field reset value
`define FRDC_LAT_RESET 4'h0

`endif

// >>> src/frdc_pkg.sv
package frdc_pkg;

  typedef enum logic [1:0] {
    FRDC_IDLE = 2'b00,
    FRDC_DUMMY = 2'b01,
    FRDC_DATA = 2'b11,
    FRDC_REJECT = 2'b10
  } frdc_state_t;

endpackage

// >>> verif/frdc_host.sv
`timescale 1ns/100ps
module frdc_host (
  output logic sck,
  output logic lk_cs_n,
  output logic [7:0] lk_cmd,
  output logic lk_phase_end,
  input wire logic lk_data_drive,
  input wire logic lk_cmd_reject
);
  initial begin
    {sck, lk_cs_n, lk_cmd, lk_phase_end} = 11'h200;
  end
  ////////////////////////////////
  // clock only inside frames; fixed rate, count picked per command
  // no data lines modelled, so mode bits never contend
  task automatic tick();
    #3 sck = 1'b1;
    #3 sck = 1'b0;
  endtask
  task automatic frame(input logic [7:0] c, input logic [4:0] g, output logic [4:0] n,
                       output logic r);
    n = 5'h0;
    lk_cmd = c;
    lk_cs_n = 1'b0;
    repeat (g) tick();
    lk_phase_end = 1'b1;
    tick();
    lk_phase_end = 1'b0;
    r = lk_cmd_reject;
    for (int i = 1; i < 17 && n == 5'h0; i++) begin
      tick();
      if (lk_data_drive === 1'b1) n = 5'(i);
    end
    // one more serial clock so the registered drive flag is sampled in frame
    tick();
    lk_cs_n = 1'b1;
    lk_cmd = ~c;
  endtask
endmodule

// >>> verif/frdc_props.sv
`timescale 1ns/100ps
module frdc_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] cfg_latency,
  input wire logic cfg_quad_command_mode,
  input wire logic sck,
  input wire logic lk_cs_n,
  input wire logic [7:0] lk_cmd,
  input wire logic lk_phase_end,
  input wire logic lk_data_drive,
  input wire logic lk_cmd_reject,
  input wire logic [3:0] lk_dummy_count,
  input wire logic read_start,
  input wire logic read_refused
);
  wire z = lk_phase_end && cfg_latency == 4'h0;
  wire q = cfg_quad_command_mode;
  wire [7:0] c = lk_cmd;
  wire [3:0] k = lk_dummy_count;
  default clocking @(posedge sck); endclocking
  // frame end clears link state, so nothing is judged outside a frame
  default disable iff (!arst_n || lk_cs_n);
  ////////////////////////////////
  // flag set on the 8th edge is first sampled high on the 9th
  sequence s_wait8; !lk_data_drive [*8] ##1 lk_data_drive; endsequence
  property p_lat; lk_phase_end && cfg_latency != 4'h0 && c == 8'heb |=> k == $past(cfg_latency); endproperty
  property p_sgl; z && !q && (c == 8'h0b || c == 8'h0d) |=> k == 4'h8; endproperty
  property p_sglq; z && q && c == 8'h0d |=> k == 4'h6; endproperty
  property p_dio; z && c == 8'hbb |=> k == 4'h4; endproperty
  property p_qio; z && (c == 8'heb || c == 8'hed) |=> k == 4'h6; endproperty
  property p_bdq; lk_phase_end && q && c == 8'hbd |=> lk_cmd_reject && k == 4'h0; endproperty
  property p_uid; z && c == 8'h4b |=> k == (q ? 4'h6 : 4'h8); endproperty
  property p_drv; z && !q && c == 8'h0b |=> s_wait8; endproperty
  property p_dout; z && (c == 8'h3b || c == 8'h6b) |=> k == 4'h8; endproperty
  a_lat: assert property (p_lat) else $error("latency");
  a_sgl: assert property (p_sgl) else $error("single");
  a_sglq: assert property (p_sglq) else $error("single quad");
  a_dio: assert property (p_dio) else $error("dual io");
  a_qio: assert property (p_qio) else $error("quad io");
  a_bdq: assert property (p_bdq) else $error("refuse");
  a_uid: assert property (p_uid) else $error("id read");
  a_drv: assert property (p_drv) else $error("drive");
  a_dout: assert property (p_dout) else $error("output read");
endmodule
bind frdc_dummy_select frdc_props frdc_props_i (.clk(clk), .arst_n(arst_n),
  .cfg_latency(cfg_latency), .cfg_quad_command_mode(cfg_quad_command_mode), .sck(sck),
  .lk_cs_n(lk_cs_n), .lk_cmd(lk_cmd), .lk_phase_end(lk_phase_end),
  .lk_data_drive(lk_data_drive), .lk_cmd_reject(lk_cmd_reject),
  .lk_dummy_count(lk_dummy_count), .read_start(read_start), .read_refused(read_refused));

// >>> verif/tb.sv
`timescale 1ns/100ps
module tb;
  logic clk, arst_n, q, sck, cs_n, pe, drv, rej, rs, rf;
  logic [3:0] lat, cnt;
  logic [7:0] cmd;
  int error_cnt, cmp_count, starts, refs;
  frdc_dummy_select frdc_dummy_select_i (.clk(clk), .arst_n(arst_n), .cfg_latency(lat),
    .cfg_quad_command_mode(q), .sck(sck), .lk_cs_n(cs_n), .lk_cmd(cmd), .lk_phase_end(pe),
    .lk_data_drive(drv), .lk_cmd_reject(rej), .lk_dummy_count(cnt), .read_start(rs),
    .read_refused(rf));
  frdc_host frdc_host_i (.sck(sck), .lk_cs_n(cs_n), .lk_cmd(cmd), .lk_phase_end(pe),
    .lk_data_drive(drv), .lk_cmd_reject(rej));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    starts += (rs === 1'b1);
    refs += (rf === 1'b1);
  end
  ////////////////////////////////
  function automatic logic [4:0] exp_n(logic [7:0] c, logic [3:0] l, logic m);
    case (c)
      8'h0b, 8'h0d, 8'h4b, 8'h68: exp_n = m ? 5'h6 : 5'h8;
      8'h5a, 8'h3b, 8'h6b: exp_n = 5'h8;
      8'hbb, 8'hbd: exp_n = 5'h4;
      8'heb, 8'hed: exp_n = 5'h6;
      default: return 5'h0;
    endcase
    if (c == 8'hbd && m) exp_n = 5'h0;
    else if (l != 4'h0) exp_n = {1'b0, l};
  endfunction
  task automatic cmp(input logic [4:0] g, input logic [4:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [7:0] c, input logic [3:0] l, input logic m,
                     input logic [4:0] g);
    logic [4:0] e, n;
    logic r;
    int s0, f0;
    e = exp_n(c, l, m);
    s0 = starts;
    f0 = refs;
    @(posedge clk);
    lat <= l;
    q <= m;
    repeat (3) @(posedge clk);
    frdc_host_i.frame(c, g, n, r);
    repeat (8) @(posedge clk);
    cmp(n, e);
    cmp({4'h0, r}, {4'h0, e == 5'h0});
    cmp({1'b0, cnt}, e);
    cmp(5'(starts - s0), {4'h0, e != 5'h0});
    cmp(5'(refs - f0), {4'h0, e == 5'h0});
  endtask
  ////////////////////////////////
  task automatic t_defaults();
    logic [7:0] c [11] = '{8'h0b, 8'h0d, 8'h3b, 8'hbb, 8'hbd, 8'h6b, 8'heb, 8'hed, 8'h4b,
                          8'h5a, 8'h68};
    for (int m = 0; m < 2; m++) begin
      foreach (c[i]) run(c[i], 4'h0, m[0], 5'h2);
    end
    $display("defaults done");
  endtask
  task automatic t_latency();
    run(8'heb, 4'h1, 1'b0, 5'h5);
    run(8'h0d, 4'hf, 1'b1, 5'h2);
    run(8'h6b, 4'h7, 1'b0, 5'h3);
    run(8'hbd, 4'hf, 1'b1, 5'h2);
    run(8'h02, 4'h3, 1'b0, 5'h2);
    $display("latency done");
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {arst_n, q, lat, error_cnt, cmp_count, starts, refs} = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_defaults();
    t_latency();
    summarize();
  end
  // cuts a hang well past the whole run
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule
